// *** pkg/snc_pkg.sv ***
// What this block does
// - column address is 12 bits; only bytes 0 to 2175 exist and are written
// - row address low six bits pick the page, bits 15 to 6 the block
// - correction on: only first 64 of 128 spare bytes programmable; all readable
// - modes 0 and 3: inputs taken on rising clock, outputs changed on falling
// - two-lane commands use lanes 0 and 1; four-lane ones add lanes 2 and 3
// - double-rate quad read moves four bits on each clock edge
// - pause works only with quad enable zero; otherwise pin is lane 3
// - pause starts and ends on pause pin edges, taking effect with clock low
// - paused: output floats, input and clock ignored, array work continues
// - chip select rising during pause resets the interface logic
// - lock bit set and protect pin low with quad enable zero freezes protect, invert, complement bits
// - 0fh reads a feature live until select rises; 1fh writes one feature byte
// - 13h, 10h and d8h take a 24-bit row address, most significant first
// - 03h, 0bh, 3bh, 6bh: 16 column clocks then one dummy byte
// - bbh: 8 column clocks then 4 dummy; ebh: 4 column clocks then 4 dummy
// - eeh: 4 double-rate address clocks then eight dummy clocks
// - random-data loads 84h, c4h, 34h only accepted during internal data move
// - ffh aborts array work and clears fail, latch and correction status
// - 66h then 99h restores status and cache to power-on state
// - 9fh plus dummy byte returns maker byte then part byte
// - program and erase need the write enable latch set by 06h
package snc_pkg;
	localparam int unsigned CACHE_BYTES    = 2176;
	localparam logic [11:0] COL_LAST       = 12'h87f;
	localparam logic [11:0] SPARE_PROG_END = 12'h83f;
	localparam int unsigned FIFO_DEPTH     = 32;
	localparam logic [7:0] OP_WRITE_ENABLE_COMMAND     = 8'h06;
	localparam logic [7:0] OP_WRDI     = 8'h04;
	localparam logic [7:0] OP_GET_FEAT = 8'h0f;
	localparam logic [7:0] OP_SET_FEAT = 8'h1f;
	localparam logic [7:0] OP_PAGE_RD  = 8'h13;
	localparam logic [7:0] OP_READ     = 8'h03;
	localparam logic [7:0] OP_FREAD    = 8'h0b;
	localparam logic [7:0] OP_READ_X2  = 8'h3b;
	localparam logic [7:0] OP_READ_X4  = 8'h6b;
	localparam logic [7:0] OP_READ_DIO = 8'hbb;
	localparam logic [7:0] OP_READ_QIO = 8'heb;
	localparam logic [7:0] OP_READ_DTR = 8'hee;
	localparam logic [7:0] OP_READ_ID  = 8'h9f;
	localparam logic [7:0] OP_LOAD     = 8'h02;
	localparam logic [7:0] OP_LOAD_X4  = 8'h32;
	localparam logic [7:0] OP_PROG_EX  = 8'h10;
	localparam logic [7:0] OP_RLOAD    = 8'h84;
	localparam logic [7:0] OP_RLOAD_A  = 8'hc4;
	localparam logic [7:0] OP_RLOAD_B  = 8'h34;
	localparam logic [7:0] OP_ERASE    = 8'hd8;
	localparam logic [7:0] OP_RESET    = 8'hff;
	localparam logic [7:0] OP_POR_EN   = 8'h66;
	localparam logic [7:0] OP_POR      = 8'h99;
	// edge events per phase; double-rate phases count both edges
	localparam logic [5:0] EV_ROW     = 6'd24;
	localparam logic [5:0] EV_COL     = 6'd16;
	localparam logic [5:0] EV_COL_X2  = 6'd8;
	localparam logic [5:0] EV_COL_X4  = 6'd4;
	localparam logic [5:0] EV_COL_DTR = 6'd8;
	localparam logic [5:0] EV_FADDR   = 6'd8;
	localparam logic [4:0] EV_DUM     = 5'd8;
	localparam logic [4:0] EV_DUM_X2  = 5'd4;
	localparam logic [4:0] EV_DUM_X4  = 5'd4;
	localparam logic [4:0] EV_DUM_DTR = 5'd16;
	localparam logic [7:0] FA_PROT = 8'ha0;
	localparam logic [7:0] FA_CFG  = 8'hb0;
	localparam logic [7:0] FA_STAT = 8'hc0;
	localparam int unsigned PROT_LOCK  = 7;
	localparam logic [7:0]  PROT_GUARD = 8'h3e;
	localparam logic [7:0]  PROT_RST   = 8'h38;
	localparam int unsigned CFG_QE     = 0;
	localparam int unsigned CFG_ECC    = 4;
	localparam logic [7:0]  CFG_MASK   = 8'h11;
	localparam logic [7:0]  CFG_RST    = 8'h10;
	localparam int unsigned ST_OIP  = 0;
	localparam int unsigned ST_WEL  = 1;
	localparam int unsigned ST_EF   = 2;
	localparam int unsigned ST_PF   = 3;
	localparam int unsigned ST_CORR = 4;
	typedef enum logic [2:0] {
		PH_OP = 3'b000, PH_ADDR = 3'b001, PH_DUMMY = 3'b011,
		PH_DOUT = 3'b010, PH_DIN = 3'b110, PH_DONE = 3'b100
	} snc_phase_t;
	typedef enum logic [2:0] {K_NONE, K_ROW, K_READ, K_FGET, K_FSET, K_ID, K_LOAD, K_BAD} snc_kind_t;
	typedef enum logic [1:0] {A_READ, A_PROG, A_ERASE, A_ABORT} snc_aop_t;
	typedef struct packed {
		snc_kind_t  kind;
		logic [2:0] aw;
		logic [2:0] dw;
		logic       dtr;
		logic [5:0] aev;
		logic [4:0] dev;
	} snc_plan_t;
	typedef struct packed {
		logic [9:0] block;
		logic [5:0] page;
	} snc_row_t;
	typedef struct packed {
		logic     valid;
		snc_aop_t aop;
		snc_row_t row;
	} snc_areq_t;
	typedef struct packed {
		logic       done;
		logic       pfail;
		logic       efail;
		logic [1:0] corr;
	} snc_aevt_t;
endpackage

// *** hw/snc_port.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====================================================
// load buffer between the serial side and the cache
module snc_fifo #(
	parameter int unsigned W     = 8,
	parameter int unsigned DEPTH = 32
) (
	input  wire logic         clk_in,
	input  wire logic         rstn_in,
	input  wire logic         in_valid_in,
	output logic              in_ready_out,
	input  wire logic [W-1:0] in_data_in,
	output logic              out_valid_out,
	input  wire logic         out_ready_in,
	output logic [W-1:0]      out_data_out
);
	// depth must be a power of two so the pointers wrap by themselves
	localparam int unsigned AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} snc_fifo_st_t;
	snc_fifo_st_t s;
	snc_fifo_st_t next_s;
	logic [W-1:0] mem [DEPTH];
	logic         push;
	logic         pop;
	assign in_ready_out  = s.cnt != FULL;
	assign out_valid_out = s.cnt != '0;
	assign out_data_out  = mem[s.rp];
	assign push = in_valid_in & in_ready_out;
	assign pop  = out_valid_out & out_ready_in;
	always_comb begin
		next_s = s;
		if (push) next_s.wp = s.wp + 1'b1;
		if (pop) next_s.rp = s.rp + 1'b1;
		next_s.cnt = s.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) s <= '0;
		else s <= next_s;
	end
	always_ff @(posedge clk_in) begin
		if (push) mem[s.wp] <= in_data_in;
	end
endmodule

// ====================================================
// serial command port
module snc_port #(
	parameter logic [7:0]  MFR_ID     = 8'h5a,
	parameter logic [7:0]  PART_ID    = 8'ha5,
	parameter int unsigned FIFO_DEPTH = snc_pkg::FIFO_DEPTH
) (
	input  wire logic              clk_in,
	input  wire logic              rstn_in,
	input  wire logic              sclk_in,
	input  wire logic              cs_n_in,
	input  wire logic [3:0]        lane_in,
	output logic [3:0]             lane_out,
	output logic [3:0]             lane_oe_out,
	input  wire logic              arr_busy_in,
	input  wire snc_pkg::snc_aevt_t arr_evt_in,
	output snc_pkg::snc_areq_t     arr_req_out,
	output logic [7:0]             prot_out,
	output logic [7:0]             cfg_out,
	output logic                   load_overrun_out
);
	import snc_pkg::*;
	typedef struct packed {
		logic [1:0] sclk_s;
		logic [1:0] cs_s;
		logic [3:0] ln1;
		logic [3:0] ln2;
		logic       sclk_d;
		snc_phase_t ph;
		logic [7:0] op;
		snc_plan_t  pl;
		logic [5:0] cnt;
		logic [31:0] sh;
		logic [11:0] col;
		logic [7:0] osh;
		logic [3:0] orem;
		logic       id_n;
		logic [3:0] lo;
		logic       held;
		logic       write_enable_latch;
		logic [7:0] prot;
		logic [7:0] cfg;
		logic       pf;
		logic       ef;
		logic [1:0] corr;
		logic       move;
		logic       arm;
		logic       wiping;
		logic [11:0] wipe;
		snc_areq_t  req;
		logic       ovr;
	} snc_port_st_t;

	snc_port_st_t s;
	snc_port_st_t n;
	logic [7:0]  cache [CACHE_BYTES];
	logic        rise, fall, cs_act, active, ev, dec, fset_wr;
	logic        push_v, push_rdy, pop_v, wr_en;
	logic [2:0]  w;
	logic [31:0] sv;
	logic [7:0]  fb;
	logic [19:0] pop_d;
	logic [11:0] wcol;
	snc_phase_t  dph;

	// ====================================================
	// helpers
	function automatic logic [31:0] shin(input logic [31:0] v, input logic [2:0] wd, input logic [3:0] l);
		case (wd)
			3'd2: shin = {v[29:0], l[1:0]};
			3'd4: shin = {v[27:0], l};
			default: shin = {v[30:0], l[0]};
		endcase
	endfunction

	function automatic logic [3:0] lanes_of(input logic [7:0] b, input logic [2:0] wd);
		case (wd)
			3'd2: lanes_of = {2'b00, b[7:6]};
			3'd4: lanes_of = b[7:4];
			default: lanes_of = {2'b00, b[7], 1'b0};
		endcase
	endfunction

	function automatic snc_plan_t plan_of(input logic [7:0] op, input logic qe, input logic mv);
		snc_plan_t p;
		p = '{K_BAD, 3'd1, 3'd1, 1'b0, 6'd0, 5'd0};
		case (op)
			OP_WRITE_ENABLE_COMMAND, OP_WRDI, OP_RESET, OP_POR_EN, OP_POR: p.kind = K_NONE;
			OP_PAGE_RD, OP_PROG_EX, OP_ERASE: begin
				p.kind = K_ROW;
				p.aev = EV_ROW;
			end
			OP_READ, OP_FREAD, OP_READ_X2, OP_READ_X4: begin
				p.kind = K_READ;
				p.aev = EV_COL;
				p.dev = EV_DUM;
				if (op == OP_READ_X2) p.dw = 3'd2;
				if (op == OP_READ_X4) p.dw = 3'd4;
				if (op == OP_READ_X4 && !qe) p.kind = K_BAD;
			end
			OP_READ_DIO: p = '{K_READ, 3'd2, 3'd2, 1'b0, EV_COL_X2, EV_DUM_X2};
			OP_READ_QIO: p = '{qe ? K_READ : K_BAD, 3'd4, 3'd4, 1'b0, EV_COL_X4, EV_DUM_X4};
			OP_READ_DTR: p = '{qe ? K_READ : K_BAD, 3'd4, 3'd4, 1'b1, EV_COL_DTR, EV_DUM_DTR};
			OP_GET_FEAT: begin
				p.kind = K_FGET;
				p.aev = EV_FADDR;
			end
			OP_SET_FEAT: begin
				p.kind = K_FSET;
				p.aev = EV_FADDR;
			end
			OP_READ_ID: begin
				p.kind = K_ID;
				p.dev = EV_DUM;
			end
			OP_LOAD, OP_LOAD_X4, OP_RLOAD, OP_RLOAD_A, OP_RLOAD_B: begin
				p.kind = K_LOAD;
				p.aev = EV_COL;
				if (op != OP_LOAD && op != OP_RLOAD) p.dw = 3'd4;
				if (p.dw == 3'd4 && !qe) p.kind = K_BAD;
				if ((op == OP_RLOAD || op == OP_RLOAD_A || op == OP_RLOAD_B) && !mv) p.kind = K_BAD;
			end
			default: ;
		endcase
		return p;
	endfunction

	function automatic logic [7:0] feat(input logic [7:0] a, input snc_port_st_t t, input logic busy);
		logic [7:0] st;
		st = '0;
		st[ST_OIP] = busy;
		st[ST_WEL] = t.write_enable_latch;
		st[ST_EF] = t.ef;
		st[ST_PF] = t.pf;
		st[ST_CORR +: 2] = t.corr;
		case (a)
			FA_PROT: feat = t.prot;
			FA_CFG:  feat = t.cfg;
			FA_STAT: feat = st;
			default: feat = 8'h00;
		endcase
	endfunction

	// ====================================================
	// serial engine
	always_comb begin
		n = s;
		n.req.valid = 1'b0;
		n.sclk_s = {s.sclk_s[0], sclk_in};
		n.cs_s = {s.cs_s[0], cs_n_in};
		n.ln1 = lane_in;
		n.ln2 = s.ln1;
		n.sclk_d = s.sclk_s[1];
		rise = s.sclk_s[1] & ~s.sclk_d;
		fall = ~s.sclk_s[1] & s.sclk_d;
		cs_act = ~s.cs_s[1];
		dec = 1'b0;
		fset_wr = 1'b0;
		push_v = 1'b0;
		fb = 8'hff;
		dph = (s.pl.kind == K_FSET || s.pl.kind == K_LOAD) ? PH_DIN : PH_DOUT;
		// pause only sampled while the clock is low, so a late clock edge cannot split it
		if (!cs_act || s.cfg[CFG_QE]) n.held = 1'b0;
		else if (!s.sclk_s[1]) n.held = ~s.ln2[3];
		active = cs_act & ~s.held;
		w = (s.ph == PH_OP) ? 3'd1 : ((s.ph == PH_ADDR) ? s.pl.aw : s.pl.dw);
		ev = rise | (s.pl.dtr & fall & (s.ph != PH_OP));
		sv = shin(s.sh, w, s.ln2);
		if (s.wiping) begin
			n.wipe = s.wipe + 12'd1;
			if (s.wipe == COL_LAST) n.wiping = 1'b0;
		end
		if (!cs_act) begin
			n.ph = PH_OP;
			n.cnt = '0;
			n.sh = '0;
			n.orem = '0;
			n.id_n = 1'b0;
			n.pl = '{K_NONE, 3'd1, 3'd1, 1'b0, 6'd0, 5'd0};
		end else if (active && ev) begin
			unique case (s.ph)
				PH_OP: begin
					n.sh = sv;
					n.cnt = s.cnt + 6'd1;
					if (s.cnt == 6'd7) begin
						dec = 1'b1;
						n.op = sv[7:0];
						n.pl = plan_of(sv[7:0], s.cfg[CFG_QE], s.move);
						n.cnt = '0;
						n.sh = '0;
						if (n.pl.kind == K_NONE || n.pl.kind == K_BAD) n.ph = PH_DONE;
						else if (n.pl.aev != '0) n.ph = PH_ADDR;
						else n.ph = PH_DUMMY;
					end
				end
				PH_ADDR: begin
					n.sh = sv;
					n.cnt = s.cnt + 6'd1;
					if (n.cnt == s.pl.aev) begin
						n.cnt = '0;
						n.col = sv[11:0];
						if (s.pl.kind == K_ROW) begin
							n.ph = PH_DONE;
							n.req.row = sv[15:0];
							if (s.op == OP_PAGE_RD) begin
								n.req.valid = 1'b1;
								n.req.aop = A_READ;
								n.move = 1'b1;
							end else if (s.write_enable_latch) begin
								n.req.valid = 1'b1;
								n.req.aop = (s.op == OP_ERASE) ? A_ERASE : A_PROG;
								n.write_enable_latch = 1'b0;
								if (s.op == OP_PROG_EX) n.move = 1'b0;
							end
						end else n.ph = (s.pl.dev != '0) ? PH_DUMMY : dph;
					end
				end
				PH_DUMMY: begin
					n.cnt = s.cnt + 6'd1;
					if (n.cnt[4:0] == s.pl.dev) begin
						n.cnt = '0;
						n.ph = dph;
					end
				end
				PH_DIN: begin
					n.sh = sv;
					n.cnt = s.cnt + {3'd0, s.pl.dw};
					if (n.cnt == 6'd8) begin
						n.cnt = '0;
						if (s.pl.kind == K_FSET) begin
							fset_wr = 1'b1;
							n.ph = PH_DONE;
						end else begin
							push_v = 1'b1;
							n.col = s.col + 12'd1;
						end
					end
				end
				PH_DOUT, PH_DONE: ;
			endcase
		end
		// outputs change on falling edges, or on both edges in double-rate reads
		if (active && s.ph == PH_DOUT && (fall || (s.pl.dtr && rise))) begin
			if (s.orem == '0) begin
				case (s.pl.kind)
					K_READ: fb = (s.col <= COL_LAST) ? cache[s.col] : 8'hff;
					K_FGET: fb = feat(s.sh[7:0], s, arr_busy_in);
					K_ID: fb = s.id_n ? PART_ID : MFR_ID;
					default: fb = 8'hff;
				endcase
				n.lo = lanes_of(fb, s.pl.dw);
				n.osh = fb << s.pl.dw;
				n.orem = 4'd8 - {1'b0, s.pl.dw};
				n.col = s.col + 12'd1;
				n.id_n = 1'b1;
			end else begin
				n.lo = lanes_of(s.osh, s.pl.dw);
				n.osh = s.osh << s.pl.dw;
				n.orem = s.orem - {1'b0, s.pl.dw};
			end
		end
		if (fset_wr) begin
			if (sv[15:8] == FA_PROT) begin
				// lock only holds while the protect pin is a protect pin
				if (s.prot[PROT_LOCK] && !s.ln2[2] && !s.cfg[CFG_QE]) begin
					n.prot = (s.prot & PROT_GUARD) | (sv[7:0] & ~PROT_GUARD);
				end else n.prot = sv[7:0];
			end
			if (sv[15:8] == FA_CFG) n.cfg = sv[7:0] & CFG_MASK;
		end
		if (dec) begin
			n.arm = (n.op == OP_POR_EN);
			case (n.op)
				OP_WRITE_ENABLE_COMMAND: n.write_enable_latch = 1'b1;
				OP_WRDI: n.write_enable_latch = 1'b0;
				OP_LOAD, OP_LOAD_X4: n.move = 1'b0;
				OP_RESET, OP_POR: begin
					if (n.op == OP_RESET || s.arm) begin
						n.write_enable_latch = 1'b0;
						n.pf = 1'b0;
						n.ef = 1'b0;
						n.corr = '0;
						n.move = 1'b0;
						n.req.valid = 1'b1;
						n.req.aop = A_ABORT;
					end
					if (n.op == OP_POR && s.arm) begin
						n.prot = PROT_RST;
						n.cfg = CFG_RST;
						n.wiping = 1'b1;
						n.wipe = '0;
					end
				end
				default: ;
			endcase
		end
		// array results win over a reset clearing them in the same cycle
		if (arr_evt_in.pfail) n.pf = 1'b1;
		if (arr_evt_in.efail) n.ef = 1'b1;
		if (arr_evt_in.done) n.corr = arr_evt_in.corr;
		n.ovr = push_v & ~push_rdy;
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s <= '0;
			s.cs_s <= 2'b11;
			s.prot <= PROT_RST;
			s.cfg <= CFG_RST;
		end else s <= n;
	end

	// ====================================================
	// load path into the cache; the wipe stalls the drain side
	snc_fifo #(.W(20), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_in        (clk_in),
		.rstn_in       (rstn_in),
		.in_valid_in   (push_v),
		.in_ready_out  (push_rdy),
		.in_data_in    ({s.col, sv[7:0]}),
		.out_valid_out (pop_v),
		.out_ready_in  (~s.wiping),
		.out_data_out  (pop_d)
	);
	assign wcol = pop_d[19:8];
	assign wr_en = pop_v & ~s.wiping & (wcol <= COL_LAST)
		& (~s.cfg[CFG_ECC] | (wcol <= SPARE_PROG_END));
	always_ff @(posedge clk_in) begin
		if (s.wiping) cache[s.wipe] <= 8'hff;
		else if (wr_en) cache[wcol] <= pop_d[7:0];
	end

	always_comb begin
		lane_oe_out = 4'h0;
		if (cs_act && !s.held && s.ph == PH_DOUT) begin
			case (s.pl.dw)
				3'd2: lane_oe_out = 4'h3;
				3'd4: lane_oe_out = 4'hf;
				default: lane_oe_out = 4'h2;
			endcase
		end
	end
	assign lane_out = s.lo;
	assign arr_req_out = s.req;
	assign prot_out = s.prot;
	assign cfg_out = s.cfg;
	assign load_overrun_out = s.ovr;

	// ====================================================
	// checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	sequence s_write_enable_command;
		dec && n.op == OP_WRITE_ENABLE_COMMAND;
	endsequence
	sequence s_por;
		s.arm ##0 (dec && n.op == OP_POR);
	endsequence
	a_exec_needs_wel: assert property (s.req.valid && s.req.aop inside {A_PROG, A_ERASE} |-> $past(s.write_enable_latch) && !s.write_enable_latch)
		else $error("array write issued without latch");
	a_write_enable_command_sets: assert property (s_write_enable_command |=> s.write_enable_latch)
		else $error("write enable did not set latch");
	a_reset_clears: assert property (dec && n.op == OP_RESET |=> !s.write_enable_latch && s.req.valid && s.req.aop == A_ABORT)
		else $error("soft reset incomplete");
	a_por_restore: assert property (s_por |=> s.wiping && s.cfg == CFG_RST && s.prot == PROT_RST ##1 s.wiping[*8])
		else $error("power-on restore incomplete");
	a_hold_float: assert property (s.held |-> lane_oe_out == 4'h0)
		else $error("output driven while paused");
	a_quad_no_hold: assert property (s.cfg[CFG_QE] |=> !s.held)
		else $error("pause active with quad enable");
	a_cs_restart: assert property (s.cs_s[1] |=> s.ph == PH_OP && !s.held)
		else $error("interface not reset on deselect");
	a_spare_write: assert property (wr_en |-> wcol <= COL_LAST && (!s.cfg[CFG_ECC] || wcol <= SPARE_PROG_END))
		else $error("write outside programmable area");
	a_out_on_fall: assert property ($changed(s.lo) && !$past(s.pl.dtr) |-> $past(fall))
		else $error("output changed off falling edge");
	a_protect_guard: assert property (fset_wr && sv[15:8] == FA_PROT && s.prot[PROT_LOCK] && !s.ln2[2]
		&& !s.cfg[CFG_QE] |=> (s.prot & PROT_GUARD) == $past(s.prot & PROT_GUARD))
		else $error("protect bits changed while locked");
endmodule
`default_nettype wire

// *** verification/snc_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====================================================
// host side of the serial link, mode 0: clock idles low
module snc_host (
	input  wire logic       clk_in,
	input  wire logic [3:0] pin_in,
	output logic            sclk_out,
	output logic            cs_n_out,
	output logic [3:0]      lane_out,
	output logic [3:0]      lane_oe_out
);
	initial begin
		sclk_out    = 1'b0;
		cs_n_out    = 1'b1;
		lane_out    = 4'hc;
		lane_oe_out = 4'hc;
	end
	task automatic half();
		repeat (4) @(posedge clk_in);
	endtask
	// clock moves only inside a frame
	task automatic open_frame();
		@(posedge clk_in);
		cs_n_out <= 1'b0;
		half();
	endtask
	// select dropped after every command, never left asserted
	task automatic close_frame();
		half();
		cs_n_out       <= 1'b1;
		lane_oe_out[0] <= 1'b0;
		half();
	endtask
	// data set while clock is low, taken on the rise
	task automatic put_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			lane_out[0]    <= b[i];
			lane_oe_out[0] <= 1'b1;
			half();
			sclk_out <= 1'b1;
			half();
			sclk_out <= 1'b0;
		end
	endtask
	// sampled late in the low phase, after the falling-edge update
	task automatic get_byte(output logic [7:0] b);
		lane_oe_out[0] <= 1'b0;
		for (int i = 7; i >= 0; i--) begin
			half();
			b[i] = pin_in[1];
			sclk_out <= 1'b1;
			half();
			sclk_out <= 1'b0;
		end
	endtask
	// protect and pause are plain pins in single-lane use; only moved with clock low
	task automatic set_pins(input logic wp_n, input logic pause_n);
		@(posedge clk_in);
		lane_out[3:2] <= {pause_n, wp_n};
	endtask
endmodule
`default_nettype wire

// *** verification/tb_serial_nand_command_port.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
	$display("unexpected %s expected %h seen %h", what, exp, got); end end
module tb_serial_nand_command_port;
	import snc_pkg::*;
	localparam logic [7:0] MFR = 8'h3c; // arbitrary maker code
	localparam logic [7:0] PRT = 8'hc3; // arbitrary part code
	logic       clk_in      = 1'b0;
	logic       rstn_in     = 1'b0;
	logic       arr_busy_in = 1'b0;
	snc_aevt_t  arr_evt_in  = '0;
	logic       sclk, cs_n, ovr;
	logic       junk = 1'b0;
	logic [3:0] h_lane, h_oe, d_lane, d_oe, pins;
	logic [7:0] prot, cfg, v, w;
	snc_areq_t  req, last_req;
	int         num_errors = 0;
	int         n_compared = 0;
	int         n_req      = 0;
	int         n_ovr      = 0;
	// ====================================================
	// pin resolution; a released lane toggles rather than holding its last value
	always @(posedge clk_in) junk <= ~junk;
	assign pins = (d_oe & d_lane) | (~d_oe & h_oe & h_lane) | (~d_oe & ~h_oe & {4{junk}});
	initial begin
		forever #50 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		if (req.valid === 1'b1) begin
			n_req    <= n_req + 1;
			last_req <= req;
		end
		// a dropped load byte would be silent at the pins
		if (ovr === 1'b1) n_ovr <= n_ovr + 1;
	end
	snc_port #(.MFR_ID(MFR), .PART_ID(PRT), .FIFO_DEPTH(FIFO_DEPTH)) dut_u (
		.clk_in(clk_in), .rstn_in(rstn_in), .sclk_in(sclk), .cs_n_in(cs_n), .lane_in(pins),
		.lane_out(d_lane), .lane_oe_out(d_oe), .arr_busy_in(arr_busy_in), .arr_evt_in(arr_evt_in),
		.arr_req_out(req), .prot_out(prot), .cfg_out(cfg), .load_overrun_out(ovr));
	snc_host host_u (.clk_in(clk_in), .pin_in(pins), .sclk_out(sclk), .cs_n_out(cs_n),
		.lane_out(h_lane), .lane_oe_out(h_oe));
	// ====================================================
	// command tasks
	task automatic test_done();
		if (num_errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic op1(input logic [7:0] op);
		host_u.open_frame();
		host_u.put_byte(op);
		host_u.close_frame();
	endtask
	task automatic fget(input logic [7:0] a, output logic [7:0] d);
		host_u.open_frame();
		host_u.put_byte(OP_GET_FEAT);
		host_u.put_byte(a);
		host_u.get_byte(d);
		host_u.close_frame();
	endtask
	task automatic fset(input logic [7:0] a, input logic [7:0] d);
		host_u.open_frame();
		host_u.put_byte(OP_SET_FEAT);
		host_u.put_byte(a);
		host_u.put_byte(d);
		host_u.close_frame();
	endtask
	task automatic row(input logic [7:0] op, input logic [15:0] r);
		host_u.open_frame();
		host_u.put_byte(op);
		host_u.put_byte(8'h00);
		host_u.put_byte(r[15:8]);
		host_u.put_byte(r[7:0]);
		host_u.close_frame();
	endtask
	// frame stays open for data
	task automatic col_cmd(input logic [7:0] op, input logic [15:0] c);
		host_u.open_frame();
		host_u.put_byte(op);
		host_u.put_byte(c[15:8]);
		host_u.put_byte(c[7:0]);
	endtask
	task automatic load2(input logic [7:0] op, input logic [15:0] c, input logic [7:0] a, input logic [7:0] b);
		col_cmd(op, c);
		host_u.put_byte(a);
		host_u.put_byte(b);
		host_u.close_frame();
		repeat (50) @(posedge clk_in);
	endtask
	// 16 column clocks, then one dummy byte
	task automatic read2(input logic [15:0] c, output logic [7:0] a, output logic [7:0] b);
		col_cmd(OP_READ, c);
		host_u.put_byte(8'h00);
		host_u.get_byte(a);
		host_u.get_byte(b);
		host_u.close_frame();
	endtask
	initial begin
		repeat (100000) @(posedge clk_in);
		num_errors++;
		test_done();
	end
	// ====================================================
	// main sequence
	initial begin
		repeat (5) @(posedge clk_in);
		`CHK("prot_rst", 8'h38, prot)
		`CHK("cfg_rst", 8'h10, cfg)
		`CHK("oe_rst", 4'h0, d_oe)
		`CHK("req_rst", 1'b0, req.valid)
		rstn_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		fget(FA_PROT, v);
		`CHK("feat_prot", 8'h38, v)
		host_u.open_frame();
		host_u.put_byte(OP_READ_ID);
		host_u.put_byte(8'h00);
		host_u.get_byte(v);
		host_u.get_byte(w);
		host_u.close_frame();
		`CHK("maker", MFR, v)
		`CHK("part", PRT, w)
		op1(OP_WRITE_ENABLE_COMMAND);
		fget(FA_STAT, v);
		`CHK("latch_set", 8'h02, v)
		row(OP_ERASE, 16'hffc1);
		`CHK("erase_req", 1, n_req)
		`CHK("erase_aop", A_ERASE, last_req.aop)
		`CHK("erase_blk", 10'h3ff, last_req.row.block)
		`CHK("erase_pg", 6'h01, last_req.row.page)
		fget(FA_STAT, v);
		`CHK("latch_clr", 8'h00, v)
		row(OP_ERASE, 16'h0005);
		`CHK("erase_nolatch", 1, n_req)
		row(OP_PAGE_RD, 16'h0040);
		`CHK("read_aop", A_READ, last_req.aop)
		`CHK("read_blk", 10'h001, last_req.row.block)
		`CHK("read_pg", 6'h00, last_req.row.page)
		arr_busy_in <= 1'b1;
		op1(OP_WRITE_ENABLE_COMMAND);
		arr_evt_in.pfail <= 1'b1;
		@(posedge clk_in);
		arr_evt_in.pfail <= 1'b0;
		fget(FA_STAT, v);
		`CHK("stat_fail", 8'h0b, v)
		arr_busy_in <= 1'b0;
		op1(OP_RESET);
		`CHK("reset_aop", A_ABORT, last_req.aop)
		fget(FA_STAT, v);
		`CHK("stat_reset", 8'h00, v)
		fset(FA_PROT, 8'h80);
		`CHK("prot_lock", 8'h80, prot)
		host_u.set_pins(1'b0, 1'b1);
		fset(FA_PROT, 8'hbe);
		fget(FA_PROT, v);
		`CHK("prot_held", 8'h80, v)
		host_u.set_pins(1'b1, 1'b1);
		fset(FA_PROT, 8'h3e);
		`CHK("prot_free", 8'h3e, prot)
		op1(OP_POR_EN);
		op1(OP_POR);
		// the restore wipes the cache one byte per clock
		repeat (2300) @(posedge clk_in);
		load2(OP_LOAD, 16'h083f, 8'h11, 8'h22);
		read2(16'h083f, v, w);
		`CHK("spare_prog", 8'h11, v)
		`CHK("spare_lock", 8'hff, w)
		load2(OP_RLOAD, 16'h0010, 8'h55, 8'h66);
		read2(16'h0010, v, w);
		`CHK("rload_refused", 8'hff, v)
		fset(FA_CFG, 8'h00);
		`CHK("cfg_off", 8'h00, cfg)
		row(OP_PAGE_RD, 16'h0000);
		load2(OP_RLOAD, 16'h0010, 8'h55, 8'h66);
		read2(16'h0010, v, w);
		`CHK("rload_taken", 8'h55, v)
		`CHK("rload_next", 8'h66, w)
		load2(OP_LOAD, 16'h087f, 8'h33, 8'h44);
		read2(16'h087f, v, w);
		`CHK("col_last", 8'h33, v)
		`CHK("col_out", 8'hff, w)
		col_cmd(OP_READ, 16'h083f);
		host_u.put_byte(8'h00);
		host_u.get_byte(v);
		`CHK("pre_pause", 4'h2, d_oe)
		host_u.set_pins(1'b1, 1'b0);
		repeat (8) @(posedge clk_in);
		`CHK("paused_oe", 4'h0, d_oe)
		host_u.set_pins(1'b1, 1'b1);
		repeat (8) @(posedge clk_in);
		`CHK("resumed_oe", 4'h2, d_oe)
		host_u.get_byte(w);
		host_u.close_frame();
		`CHK("rd_byte", 8'h11, v)
		`CHK("rd_next", 8'hff, w)
		`CHK("no_overrun", 0, n_ovr)
		test_done();
	end
endmodule
`default_nettype wire
